// >>> vrc_pkg.sv
// Package with task-file layout, opcodes and status encodings for the verify/relocate block.
// Notes on behaviour
// - Opcodes 40h and 41h both verify sectors.
// - Sector count zero means 256 sectors.
// - Sector number register gives low address byte.
// - Cylinder registers give middle and high bytes.
// - Device/head bit 6 selects logical addressing.
// - Success clears busy and error, sets ready.
// - Unrecoverable error stops, leaves failing address.
// - Error flags at bits 6, 4, 2, 0.
// - Correctable error sets status bit 2.
// - Error summary follows error register; busy, request clear.
// - Drive fault sets status bit 5 only when an error is also reported.
// - Host issues commands only when ready.
// - Verify checks sectors, never requests data.
// - Host enters with all-ones cylinders, opcode FBh.
// - First entry command aborts but is remembered.
// - Host ignores first abort, sends confirm.
// - Confirm with 0Fh/F0h cylinders enters privileged mode.
// - Relocate F8h only privileged, count one.
// - Exit FCh only privileged, leaves mode.
// - Failed relocation aborts with error summary.
// - Relocated sector is redirected afterwards.
// - Verify covers 1 to 256 sectors from start.
package vrc_pkg;
  localparam logic [7:0] OP_VERIFY_A = 8'h40;
  localparam logic [7:0] OP_VERIFY_B = 8'h41;
  localparam logic [7:0] OP_ENTRY = 8'hFB;
  localparam logic [7:0] OP_RELOCATE = 8'hF8;
  localparam logic [7:0] OP_EXIT = 8'hFC;
  localparam logic [7:0] CYL_ALL_ONES = 8'hFF;
  localparam logic [7:0] CONFIRM_CYL_LOW = 8'h0F;
  localparam logic [7:0] CONFIRM_CYL_HIGH = 8'hF0;
  localparam logic [7:0] RELOCATE_COUNT = 8'h01;
  localparam int LBA_BIT = 6;
  // Error register bit positions.
  localparam int ERR_UNC = 6;
  localparam int ERR_ID_MISSING_FLAG = 4;
  localparam int ERR_ABORTED_FLAG = 2;
  localparam int ERR_ADDRESS_MARK_MISSING_FLAG = 0;
  // Status register bit positions.
  localparam int ST_BSY = 7;
  localparam int ST_DRIVE_READY_FLAG = 6;
  localparam int ST_DF = 5;
  localparam int ST_DRQ = 3;
  localparam int ST_CORRECTED_DATA_FLAG = 2;
  localparam int ST_ERR = 0;
  // Task-file register selects.
  localparam logic [2:0] TF_FEATURE = 3'h1;
  localparam logic [2:0] TF_COUNT = 3'h2;
  localparam logic [2:0] TF_SECTOR = 3'h3;
  localparam logic [2:0] TF_CYL_LOW = 3'h4;
  localparam logic [2:0] TF_CYL_HIGH = 3'h5;
  localparam logic [2:0] TF_UNIT_HEAD = 3'h6;
  localparam logic [2:0] TF_OPCODE = 3'h7;
  localparam logic [2:0] TF_FAULT_FLAGS = 3'h1;
  localparam logic [2:0] TF_CONDITION = 3'h7;
  // Media check result codes.
  localparam logic [2:0] MR_OK = 3'h0;
  localparam logic [2:0] MR_CORRECTED_DATA_FLAG = 3'h1;
  localparam logic [2:0] MR_UNC = 3'h2;
  localparam logic [2:0] MR_ID_MISSING_FLAG = 3'h3;
  localparam logic [2:0] MR_ADDRESS_MARK_MISSING_FLAG = 3'h4;
  // Host APB register offsets.
  localparam logic [11:0] HR_CTRL = 12'h000;
  localparam logic [11:0] HR_ADDR = 12'h004;
  localparam logic [11:0] HR_STAT = 12'h008;
  localparam logic [11:0] HR_RESULT = 12'h00C;
  localparam int HC_GO = 0;
  localparam int HC_KIND = 1;
  localparam int HS_BUSY = 0;
  localparam int HS_DONE = 1;
  localparam logic [1:0] HK_VERIFY = 2'h0;
  localparam logic [1:0] HK_RELOCATE = 2'h1;
  localparam logic [1:0] HK_EXIT = 2'h2;
  localparam logic [1:0] HK_ENTER = 2'h3;
  typedef enum logic [1:0] {VRC_PRIV_OFF, VRC_PRIV_HALF, VRC_PRIV_ON} vrc_priv_t;
endpackage

// >>> vrc_if.sv
// Interface carrying task-file accesses between host adapter and drive.
`timescale 1ns/10ps
interface vrc_if;
  logic wr;
  logic rd;
  logic [2:0] sel;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport drive (input wr, input rd, input sel, input wdata, output rdata);
  modport host (output wr, output rd, output sel, output wdata, input rdata);
endinterface

// >>> vrc_drive.sv
// Drive end: task file, verify and sector relocation command execution.
`timescale 1ns/10ps
module vrc_drive (
  input wire logic pclk,
  input wire logic presetn,
  vrc_if.drive tf,
  output logic media_req,
  output logic [27:0] media_addr,
  output logic media_lba,
  input wire logic media_ack,
  input wire logic [2:0] media_result,
  input wire logic drive_fault,
  output logic remap_req,
  input wire logic remap_ok,
  output logic verify_active
);
  typedef enum logic [1:0] {VRC_IDLE, VRC_VERIFY, VRC_RELOC, VRC_DONE} vrc_state_t;
  vrc_state_t state, next_state;
  vrc_pkg::vrc_priv_t priv, next_priv;
  logic [7:0] count, next_count;
  logic [7:0] sector, next_sector;
  logic [7:0] cyl_low, next_cyl_low;
  logic [7:0] cyl_high, next_cyl_high;
  logic [7:0] unit_head, next_unit_head;
  logic [7:0] errs, next_errs;
  logic [7:0] cond, next_cond;
  logic [8:0] left, next_left;
  logic corrected_data_flag, next_corrected_data_flag;
  logic [7:0] rdata_r, next_rdata;
  logic remap_valid, next_remap_valid;
  logic [27:0] remap_src, next_remap_src;
  logic media_req_r, next_media_req;
  logic [27:0] media_addr_r, next_media_addr;
  logic remap_req_r, next_remap_req;
  logic [27:0] cur;

  function automatic logic [7:0] finish(input logic [7:0] e, input logic c, input logic f);
    logic [7:0] s;
    s = 8'h00;
    s[vrc_pkg::ST_DRIVE_READY_FLAG] = 1'b1;
    s[vrc_pkg::ST_ERR] = |e;
    s[vrc_pkg::ST_CORRECTED_DATA_FLAG] = c;
    s[vrc_pkg::ST_DF] = f & (|e);
    return s;
  endfunction

  // Current address packed from the task file in either form.
  assign cur = {unit_head[3:0], cyl_high, cyl_low, sector};

  // ==========================================================
  // Command and task-file next-state logic
  always_comb begin
    next_state = state;
    next_priv = priv;
    next_count = count;
    next_sector = sector;
    next_cyl_low = cyl_low;
    next_cyl_high = cyl_high;
    next_unit_head = unit_head;
    next_errs = errs;
    next_cond = cond;
    next_left = left;
    next_corrected_data_flag = corrected_data_flag;
    next_remap_valid = remap_valid;
    next_remap_src = remap_src;
    next_media_req = 1'b0;
    next_media_addr = media_addr_r;
    next_remap_req = 1'b0;
    next_rdata = 8'h00;
    if (tf.rd) begin
      if (tf.sel == vrc_pkg::TF_FAULT_FLAGS) begin
        next_rdata = errs;
      end else if (tf.sel == vrc_pkg::TF_CONDITION) begin
        next_rdata = cond;
      end else if (tf.sel == vrc_pkg::TF_COUNT) begin
        next_rdata = count;
      end else if (tf.sel == vrc_pkg::TF_SECTOR) begin
        next_rdata = sector;
      end else if (tf.sel == vrc_pkg::TF_CYL_LOW) begin
        next_rdata = cyl_low;
      end else if (tf.sel == vrc_pkg::TF_CYL_HIGH) begin
        next_rdata = cyl_high;
      end else if (tf.sel == vrc_pkg::TF_UNIT_HEAD) begin
        next_rdata = unit_head;
      end
    end
    unique case (state)
      VRC_IDLE, VRC_DONE: begin
        if (state == VRC_DONE) begin
          next_state = VRC_IDLE;
        end
        if (tf.wr) begin
          unique case (tf.sel)
            vrc_pkg::TF_COUNT: next_count = tf.wdata;
            vrc_pkg::TF_SECTOR: next_sector = tf.wdata;
            vrc_pkg::TF_CYL_LOW: next_cyl_low = tf.wdata;
            vrc_pkg::TF_CYL_HIGH: next_cyl_high = tf.wdata;
            vrc_pkg::TF_UNIT_HEAD: next_unit_head = tf.wdata;
            vrc_pkg::TF_OPCODE: begin
              next_errs = 8'h00;
              next_corrected_data_flag = 1'b0;
              next_cond = 8'h00;
              next_cond[vrc_pkg::ST_BSY] = 1'b1;
              next_cond[vrc_pkg::ST_DRIVE_READY_FLAG] = 1'b1;
              next_priv = vrc_pkg::VRC_PRIV_OFF;
              next_state = VRC_DONE;
              if (tf.wdata == vrc_pkg::OP_VERIFY_A || tf.wdata == vrc_pkg::OP_VERIFY_B) begin
                next_priv = priv == vrc_pkg::VRC_PRIV_ON ? priv : vrc_pkg::VRC_PRIV_OFF;
                next_left = count == 8'h00 ? 9'h100 : {1'b0, count};
                next_media_req = 1'b1;
                next_media_addr = cur;
                next_state = VRC_VERIFY;
              end else if (tf.wdata == vrc_pkg::OP_ENTRY) begin
                if (priv == vrc_pkg::VRC_PRIV_HALF && cyl_low == vrc_pkg::CONFIRM_CYL_LOW
                    && cyl_high == vrc_pkg::CONFIRM_CYL_HIGH) begin
                  next_priv = vrc_pkg::VRC_PRIV_ON;
                end else if (cyl_low == vrc_pkg::CYL_ALL_ONES
                    && cyl_high == vrc_pkg::CYL_ALL_ONES) begin
                  next_priv = vrc_pkg::VRC_PRIV_HALF;
                  next_errs[vrc_pkg::ERR_ABORTED_FLAG] = 1'b1;
                end else begin
                  next_errs[vrc_pkg::ERR_ABORTED_FLAG] = 1'b1;
                end
              end else if (tf.wdata == vrc_pkg::OP_RELOCATE
                  && priv == vrc_pkg::VRC_PRIV_ON && count == vrc_pkg::RELOCATE_COUNT) begin
                next_priv = priv;
                next_remap_req = 1'b1;
                next_media_addr = cur;
                next_state = VRC_RELOC;
              end else if (tf.wdata == vrc_pkg::OP_EXIT && priv == vrc_pkg::VRC_PRIV_ON) begin
                next_priv = vrc_pkg::VRC_PRIV_OFF;
              end else begin
                next_errs[vrc_pkg::ERR_ABORTED_FLAG] = 1'b1;
              end
              if (next_state == VRC_DONE) begin
                next_cond = finish(next_errs, 1'b0, drive_fault);
              end
            end
            default: next_count = count;
          endcase
        end
      end
      VRC_VERIFY: begin
        // Data request never raised; only media is checked.
        if (media_ack) begin
          if (media_result == vrc_pkg::MR_OK || media_result == vrc_pkg::MR_CORRECTED_DATA_FLAG) begin
            next_corrected_data_flag = corrected_data_flag | (media_result == vrc_pkg::MR_CORRECTED_DATA_FLAG);
            next_left = left - 9'h001;
            if (left == 9'h001) begin
              next_cond = finish(errs, next_corrected_data_flag, drive_fault);
              next_state = VRC_IDLE;
            end else begin
              next_media_req = 1'b1;
              next_media_addr = media_addr_r + 28'h0000001;
            end
          end else begin
            // Failing address remains in the task file.
            next_sector = media_addr_r[7:0];
            next_cyl_low = media_addr_r[15:8];
            next_cyl_high = media_addr_r[23:16];
            next_unit_head = {unit_head[7:4], media_addr_r[27:24]};
            next_errs[vrc_pkg::ERR_UNC] = media_result == vrc_pkg::MR_UNC;
            next_errs[vrc_pkg::ERR_ID_MISSING_FLAG] = media_result == vrc_pkg::MR_ID_MISSING_FLAG;
            next_errs[vrc_pkg::ERR_ADDRESS_MARK_MISSING_FLAG] = media_result == vrc_pkg::MR_ADDRESS_MARK_MISSING_FLAG;
            next_errs[vrc_pkg::ERR_ABORTED_FLAG] = media_result > vrc_pkg::MR_ADDRESS_MARK_MISSING_FLAG;
            next_cond = finish(next_errs, corrected_data_flag, drive_fault);
            next_state = VRC_IDLE;
          end
        end
      end
      VRC_RELOC: begin
        if (media_ack) begin
          if (remap_ok) begin
            next_remap_valid = 1'b1;
            next_remap_src = media_addr_r;
            next_cond = finish(errs, 1'b0, drive_fault);
          end else begin
            next_errs[vrc_pkg::ERR_ABORTED_FLAG] = 1'b1;
            next_cond = finish(next_errs, 1'b0, drive_fault);
          end
          next_state = VRC_IDLE;
        end
      end
    endcase
  end

  // ==========================================================
  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= VRC_IDLE;
      priv <= vrc_pkg::VRC_PRIV_OFF;
      count <= 8'h01;
      sector <= 8'h01;
      cyl_low <= 8'h00;
      cyl_high <= 8'h00;
      unit_head <= 8'h00;
      errs <= 8'h00;
      cond <= 8'h40;
      left <= 9'h000;
      corrected_data_flag <= 1'b0;
      rdata_r <= 8'h00;
      remap_valid <= 1'b0;
      remap_src <= 28'h0000000;
      media_req_r <= 1'b0;
      media_addr_r <= 28'h0000000;
      remap_req_r <= 1'b0;
    end else begin
      state <= next_state;
      priv <= next_priv;
      count <= next_count;
      sector <= next_sector;
      cyl_low <= next_cyl_low;
      cyl_high <= next_cyl_high;
      unit_head <= next_unit_head;
      errs <= next_errs;
      cond <= next_cond;
      left <= next_left;
      corrected_data_flag <= next_corrected_data_flag;
      rdata_r <= next_rdata;
      remap_valid <= next_remap_valid;
      remap_src <= next_remap_src;
      media_req_r <= next_media_req;
      media_addr_r <= next_media_addr;
      remap_req_r <= next_remap_req;
    end
  end

  logic lba_r;
  logic [27:0] media_out;
  logic verify_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lba_r <= 1'b0;
      media_out <= 28'h0000000;
      verify_r <= 1'b0;
    end else begin
      lba_r <= unit_head[vrc_pkg::LBA_BIT];
      // Relocated sector goes to its alternate location.
      media_out <= (remap_valid && next_media_addr == remap_src) ?
                   {1'b1, next_media_addr[26:0]} : next_media_addr;
      verify_r <= next_state == VRC_VERIFY;
    end
  end

  assign tf.rdata = rdata_r;
  assign media_req = media_req_r;
  assign media_addr = media_out;
  assign media_lba = lba_r;
  assign remap_req = remap_req_r;
  assign verify_active = verify_r;
endmodule

// >>> vrc_host.sv
// Host end: APB-controlled adapter that issues verify and relocate sequences.
`timescale 1ns/10ps
module vrc_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  vrc_if.host tf
);
  typedef enum logic [1:0] {HS_IDLE, HS_WRITE, HS_POLL, HS_READ} vrc_hstate_t;
  vrc_hstate_t st, next_st;
  logic [7:0] prog [0:7];
  logic [7:0] next_prog [0:7];
  logic [2:0] idx, next_idx;
  logic [2:0] last, next_last;
  logic [1:0] kind, next_kind;
  logic [31:0] addr, next_addr;
  logic [7:0] count, next_count;
  logic busy, next_busy;
  logic done, next_done;
  logic [15:0] result, next_result;
  logic [31:0] prdata_r, next_prdata;
  logic wr_r, next_wr;
  logic rd_r, next_rd;
  logic [2:0] sel_r, next_sel;
  logic [7:0] wd_r, next_wd;
  logic go;
  logic [1:0] wait_rd;
  logic [1:0] next_wait_rd;

  assign go = psel && penable && pwrite && paddr == vrc_pkg::HR_CTRL
              && pwdata[vrc_pkg::HC_GO] && !busy;

  // ==========================================================
  // Sequencer and APB slave
  always_comb begin
    next_st = st;
    next_idx = idx;
    next_last = last;
    next_kind = kind;
    next_addr = addr;
    next_count = count;
    next_busy = busy;
    next_done = done;
    next_result = result;
    next_wr = 1'b0;
    next_rd = 1'b0;
    next_sel = sel_r;
    next_wd = wd_r;
    next_wait_rd = wait_rd;
    next_prdata = prdata_r;
    for (int i = 0; i < 8; i++) begin
      next_prog[i] = prog[i];
    end
    if (psel && !penable && !pwrite) begin
      unique case (paddr)
        vrc_pkg::HR_ADDR: next_prdata = addr;
        vrc_pkg::HR_STAT: next_prdata = {30'h0, done, busy};
        vrc_pkg::HR_RESULT: next_prdata = {16'h0000, result};
        vrc_pkg::HR_CTRL: next_prdata = {16'h0000, count, 5'h00, kind, 1'b0};
        default: next_prdata = 32'h00000000;
      endcase
    end
    if (psel && penable && pwrite && paddr == vrc_pkg::HR_ADDR) begin
      next_addr = pwdata;
    end
    if (psel && penable && pwrite && paddr == vrc_pkg::HR_CTRL && !busy) begin
      next_kind = pwdata[vrc_pkg::HC_KIND +: 2];
      next_count = pwdata[15:8];
      next_done = pwdata[vrc_pkg::HC_GO] ? 1'b0 : done;
    end
    unique case (st)
      HS_IDLE: begin
        if (go) begin
          next_busy = 1'b1;
          next_idx = 3'h0;
          next_st = HS_WRITE;
          next_prog[0] = pwdata[15:8];
          next_prog[1] = addr[7:0];
          next_prog[2] = addr[15:8];
          next_prog[3] = addr[23:16];
          next_prog[4] = {1'b1, addr[28], 1'b1, 1'b0, addr[27:24]};
          next_last = 3'h5;
          unique case (pwdata[vrc_pkg::HC_KIND +: 2])
            vrc_pkg::HK_VERIFY: next_prog[5] = vrc_pkg::OP_VERIFY_A;
            vrc_pkg::HK_RELOCATE: begin
              next_prog[0] = vrc_pkg::RELOCATE_COUNT;
              next_prog[5] = vrc_pkg::OP_RELOCATE;
            end
            vrc_pkg::HK_EXIT: next_prog[5] = vrc_pkg::OP_EXIT;
            vrc_pkg::HK_ENTER: begin
              // Entry, then confirm; first abort is ignored.
              next_prog[2] = vrc_pkg::CYL_ALL_ONES;
              next_prog[3] = vrc_pkg::CYL_ALL_ONES;
              next_prog[5] = vrc_pkg::OP_ENTRY;
              next_prog[6] = vrc_pkg::CONFIRM_CYL_LOW;
              next_prog[7] = vrc_pkg::CONFIRM_CYL_HIGH;
            end
          endcase
        end
      end
      HS_WRITE: begin
        next_wr = 1'b1;
        next_sel = idx + 3'h2;
        next_wd = prog[idx];
        next_idx = idx + 3'h1;
        if (idx == last) begin
          next_st = HS_POLL;
        end
        next_wait_rd = 2'h0;
      end
      HS_POLL: begin
        // Status is polled; ready must be seen before next command.
        next_rd = 1'b1;
        next_sel = vrc_pkg::TF_CONDITION;
        next_wait_rd = wait_rd + 2'h1;
        if (wait_rd == 2'h2) begin
          next_wait_rd = 2'h0;
          if (!tf.rdata[vrc_pkg::ST_BSY] && tf.rdata[vrc_pkg::ST_DRIVE_READY_FLAG]) begin
            next_result[7:0] = tf.rdata;
            next_sel = vrc_pkg::TF_FAULT_FLAGS;
            next_st = HS_READ;
            // The second entry pass rewrites both cylinders with the confirm values.
            if (kind == vrc_pkg::HK_ENTER && prog[2] == vrc_pkg::CYL_ALL_ONES) begin
              next_prog[2] = prog[6];
              next_prog[3] = prog[7];
              next_idx = 3'h2;
              next_st = HS_WRITE;
            end
          end
        end
      end
      HS_READ: begin
        next_rd = 1'b1;
        next_wait_rd = wait_rd + 2'h1;
        if (wait_rd == 2'h2) begin
          next_result[15:8] = tf.rdata;
          next_busy = 1'b0;
          next_done = 1'b1;
          next_st = HS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= HS_IDLE;
      idx <= 3'h0;
      last <= 3'h0;
      kind <= 2'h0;
      addr <= 32'h00000000;
      count <= 8'h00;
      busy <= 1'b0;
      done <= 1'b0;
      result <= 16'h0000;
      prdata_r <= 32'h00000000;
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      sel_r <= 3'h0;
      wd_r <= 8'h00;
      wait_rd <= 2'h0;
      for (int i = 0; i < 8; i++) begin
        prog[i] <= 8'h00;
      end
    end else begin
      st <= next_st;
      idx <= next_idx;
      last <= next_last;
      kind <= next_kind;
      addr <= next_addr;
      count <= next_count;
      busy <= next_busy;
      done <= next_done;
      result <= next_result;
      prdata_r <= next_prdata;
      wr_r <= next_wr;
      rd_r <= next_rd;
      sel_r <= next_sel;
      wd_r <= next_wd;
      wait_rd <= next_wait_rd;
      for (int i = 0; i < 8; i++) begin
        prog[i] <= next_prog[i];
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign tf.wr = wr_r;
  assign tf.rd = rd_r;
  assign tf.sel = sel_r;
  assign tf.wdata = wd_r;
endmodule

// >>> vrc_checker.sv
// Assertions on the task-file link and on the drive's media side.
`timescale 1ns/10ps
module vrc_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr,
  input wire logic rd,
  input wire logic [2:0] sel,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic media_req,
  input wire logic [27:0] media_addr,
  input wire logic media_lba,
  input wire logic media_ack,
  input wire logic remap_req,
  input wire logic verify_active
);
  // ==========
  // Shadow of the address registers and of the command in flight.
  logic [31:0] tf_q;
  logic [31:0] next_tf_q;
  logic first_q;
  logic next_first_q;
  logic rel_q;
  logic next_rel_q;
  always_comb begin
    next_tf_q = tf_q;
    next_first_q = first_q && !media_req;
    next_rel_q = rel_q && !media_ack;
    if (wr && sel >= vrc_pkg::TF_SECTOR && sel <= vrc_pkg::TF_UNIT_HEAD) begin
      next_tf_q[8 * (int'(sel) - 3) +: 8] = wdata;
    end
    if (wr && sel == vrc_pkg::TF_OPCODE) begin
      next_first_q = wdata == vrc_pkg::OP_VERIFY_A || wdata == vrc_pkg::OP_VERIFY_B;
      next_rel_q = wdata == vrc_pkg::OP_RELOCATE;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tf_q <= '0;
      first_q <= 1'b0;
      rel_q <= 1'b0;
    end else begin
      tf_q <= next_tf_q;
      first_q <= next_first_q;
      rel_q <= next_rel_q;
    end
  end
  // ==========
  // Properties
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_verify_starts: assert property (
    wr && sel == vrc_pkg::TF_OPCODE && wdata[7:1] == 7'h20 |-> ##[1:3] media_req)
    else $error("verify opcode started no media check");
  chk_no_data_req: assert property (
    rd && sel == vrc_pkg::TF_CONDITION |=> !rdata[vrc_pkg::ST_DRQ])
    else $error("data request seen");
  chk_ready_done: assert property (
    rd && sel == vrc_pkg::TF_CONDITION ##1 !rdata[vrc_pkg::ST_BSY] |-> rdata[vrc_pkg::ST_DRIVE_READY_FLAG])
    else $error("idle without ready");
  chk_media_pulse: assert property (
    media_req |=> !media_req) else $error("media request longer than one cycle");
  chk_remap_pulse: assert property (
    remap_req |=> !remap_req) else $error("remap request longer than one cycle");
  chk_start_addr: assert property (
    media_req && first_q |-> media_addr[23:0] == tf_q[23:0]
    && media_lba == tf_q[24 + vrc_pkg::LBA_BIT]) else $error("wrong start address");
  chk_media_verify: assert property (
    media_req |-> verify_active) else $error("media check outside verify");
  chk_remap_cause: assert property (
    remap_req |-> rel_q && !verify_active) else $error("remap without relocate opcode");
endmodule

// >>> tb_verify_and_reassign_cmd.sv
// Self-checking bench joining host and drive ends over the task-file link.
`timescale 1ns/10ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_count++; \
  $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module tb_verify_and_reassign_cmd;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic media_req;
  logic [27:0] media_addr;
  logic media_lba;
  logic media_ack = 1'b0;
  logic [2:0] media_result = 3'h0;
  logic drive_fault = 1'b0;
  logic remap_req;
  logic remap_ok = 1'b1;
  logic verify_active;
  logic [27:0] last_addr = 28'h0;
  logic [31:0] seed = 32'h0B0F;
  logic [31:0] q;
  logic [28:0] ra = {1'b1, 28'h0123456};
  logic [2:0] code = 3'h0;
  logic [7:0] cnt;
  int err_count = 0;
  int compares = 0;
  int nreq = 0;
  int base = 0;
  int fail_at = 0;
  int dly = 0;
  int fa;
  int en_x = 0;
  always #10 pclk = ~pclk;
  vrc_if u_vrc_if ();
  vrc_drive u_vrc_drive (.pclk(pclk), .presetn(presetn), .tf(u_vrc_if), .media_req(media_req),
    .media_addr(media_addr), .media_lba(media_lba), .media_ack(media_ack),
    .media_result(media_result), .drive_fault(drive_fault), .remap_req(remap_req),
    .remap_ok(remap_ok), .verify_active(verify_active));
  vrc_host u_vrc_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(), .tf(u_vrc_if));
  vrc_checker u_vrc_checker (.pclk(pclk), .presetn(presetn), .wr(u_vrc_if.wr),
    .rd(u_vrc_if.rd), .sel(u_vrc_if.sel), .wdata(u_vrc_if.wdata), .rdata(u_vrc_if.rdata),
    .media_req(media_req), .media_addr(media_addr), .media_lba(media_lba),
    .media_ack(media_ack), .remap_req(remap_req), .verify_active(verify_active));
  // ==========
  // Media side: answers each request after a varying delay; code hits one sector.
  always @(posedge pclk) begin
    media_ack <= 1'b0;
    media_result <= 3'h7;
    if (media_req || remap_req) begin
      nreq <= nreq + 1;
      dly <= 1 + nreq % 4;
      last_addr <= media_addr;
    end else if (dly > 0) begin
      dly <= dly - 1;
      if (dly == 1) begin
        media_ack <= 1'b1;
        media_result <= (nreq - base == fail_at) ? code : vrc_pkg::MR_OK;
      end
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // Code 7 stands for an aborted command.
  function automatic logic [15:0] exp_res(input logic [2:0] c, input logic f);
    logic [15:0] e;
    e = 16'h0;
    e[vrc_pkg::ST_DRIVE_READY_FLAG] = 1'b1;
    e[vrc_pkg::ST_CORRECTED_DATA_FLAG] = c == vrc_pkg::MR_CORRECTED_DATA_FLAG;
    if (c >= vrc_pkg::MR_UNC) begin
      e[vrc_pkg::ST_ERR] = 1'b1;
      e[vrc_pkg::ST_DF] = f;
      e[8 + vrc_pkg::ERR_UNC] = c == vrc_pkg::MR_UNC;
      e[8 + vrc_pkg::ERR_ID_MISSING_FLAG] = c == vrc_pkg::MR_ID_MISSING_FLAG;
      e[8 + vrc_pkg::ERR_ADDRESS_MARK_MISSING_FLAG] = c == vrc_pkg::MR_ADDRESS_MARK_MISSING_FLAG;
      e[8 + vrc_pkg::ERR_ABORTED_FLAG] = c > vrc_pkg::MR_ADDRESS_MARK_MISSING_FLAG;
    end
    return e;
  endfunction
  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 16) begin
      err_count++;
      stop_test();
    end
  endtask
  task automatic run(input logic [1:0] k, input logic [7:0] n, input logic [28:0] ad,
                     input logic [2:0] c, input int en);
    int i;
    base = nreq;
    apb(1'b1, vrc_pkg::HR_ADDR, {3'h0, ad});
    apb(1'b1, vrc_pkg::HR_CTRL, {16'h0, n, 5'h0, k, 1'b1});
    for (i = 0; i < 3000; i++) begin
      apb(1'b0, vrc_pkg::HR_STAT, 32'h0);
      if (q[vrc_pkg::HS_DONE] === 1'b1 && q[vrc_pkg::HS_BUSY] === 1'b0) break;
    end
    if (i == 3000) begin
      err_count++;
      stop_test();
    end
    apb(1'b0, vrc_pkg::HR_RESULT, 32'h0);
    `CHK("result", exp_res(c, drive_fault), q[15:0])
    `CHK("sectors", en, nreq - base)
    $display("command kind %0d finished", k);
  endtask
  // ==========
  // Main sequence
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int t = 0; t < 10; t++) begin
      seed = xs(seed);
      cnt = {5'h0, seed[2:0]} + 8'h1;
      fa = 1 + int'(seed[10:8]) % int'(cnt);
      code = 3'(t % 6);
      fail_at = fa;
      drive_fault <= code >= vrc_pkg::MR_UNC && t >= 5;
      en_x = code >= vrc_pkg::MR_UNC ? fa : int'(cnt);
      run(vrc_pkg::HK_VERIFY, cnt, {seed[20], 1'b0, seed[26:0]}, code, en_x);
      `CHK("last sector", {1'b0, seed[26:0]} + 28'(en_x - 1), last_addr)
      if (code >= vrc_pkg::MR_UNC) begin
        `CHK("fail addr", {1'b0, seed[26:0]} + 28'(fa - 1), u_vrc_drive.cur)
      end
    end
    fail_at = 0;
    drive_fault <= 1'b0;
    run(vrc_pkg::HK_VERIFY, 8'h00, ra, vrc_pkg::MR_OK, 256);
    run(vrc_pkg::HK_RELOCATE, 8'h01, ra, 3'h7, 0);
    run(vrc_pkg::HK_EXIT, 8'h00, ra, 3'h7, 0);
    run(vrc_pkg::HK_ENTER, 8'h00, ra, vrc_pkg::MR_OK, 0);
    run(vrc_pkg::HK_RELOCATE, 8'h01, ra, vrc_pkg::MR_OK, 1);
    run(vrc_pkg::HK_VERIFY, 8'h01, ra, vrc_pkg::MR_OK, 1);
    `CHK("alternate", 1'b1, last_addr[27])
    remap_ok <= 1'b0;
    run(vrc_pkg::HK_RELOCATE, 8'h01, ra, 3'h7, 1);
    remap_ok <= 1'b1;
    run(vrc_pkg::HK_EXIT, 8'h00, ra, vrc_pkg::MR_OK, 0);
    run(vrc_pkg::HK_EXIT, 8'h00, ra, 3'h7, 0);
    run(vrc_pkg::HK_ENTER, 8'h00, ra, vrc_pkg::MR_OK, 0);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    run(vrc_pkg::HK_RELOCATE, 8'h01, ra, 3'h7, 0);
    stop_test();
  end
endmodule
